// File: core/rtc_alarm_tick_seconds.sv
`timescale 1ns/1ps
// Summary of operation
// - Alarm year is six bits, 2000 to 2063
// - Alarm time writes staged, committed by year write
// - Tick wakes chip only when wake bit set
// - Ticks generated only while tick enable set
// - Alarm compare and event only while enabled
// - Seconds count read as four ascending bytes
// - Low byte read latches upper three bytes
module rtc_alarm_tick_seconds #(
  parameter int unsigned CYCLES_PER_SEC_P = rtc_pkg::CYCLES_PER_SEC
) (
  input wire logic core_clk,
  input wire logic arst_n,
  input wire rtc_pkg::reg_req_t reg_req,
  input wire rtc_pkg::cal_time_t cal,
  input wire logic rtc_only_mode,
  output logic [rtc_pkg::DATA_W-1:0] reg_rdata,
  output logic reg_rvalid,
  output logic alarm_event,
  output logic tick_event,
  output logic wake_pulse
);
  import rtc_pkg::*;

  cal_time_t hold; // Staged alarm fields awaiting the year write
  cal_time_t next_hold;
  cal_time_t active; // Alarm time the comparator uses
  cal_time_t next_active;
  ctrl_t ctrl; // Tick and alarm controls, applied at once
  ctrl_t next_ctrl;
  logic [SEC_CNT_W-1:0] sec_count; // Free-running seconds
  logic [SEC_CNT_W-1:0] next_sec_count;
  logic [SEC_CNT_W-DATA_W-1:0] snap; // Upper bytes caught at low-byte read
  logic [SEC_CNT_W-DATA_W-1:0] next_snap;
  logic [DATA_W-1:0] next_rdata;
  logic next_rvalid;
  logic next_wake;
  logic sec_pulse; // One cycle per second from the divider
  logic wr_year; // Year write in this cycle
  logic rd_low; // Low seconds byte read in this cycle

  // Decodes used only by the commit and latch checks; the logic decodes the address itself
  assign wr_year = reg_req.wr && (reg_req.addr == ADDR_ALARM_YEAR);
  assign rd_low = reg_req.rd && (reg_req.addr == ADDR_SEC_CNT0);

  // Second enable from the core clock
  rtc_sec_divider #(
    .CYCLES(CYCLES_PER_SEC_P)
  ) rtc_sec_divider_i (
    .core_clk(core_clk),
    .arst_n(arst_n),
    .sec_pulse(sec_pulse)
  );

  // Tick and alarm event decisions
  rtc_event_gen rtc_event_gen_i (
    .core_clk(core_clk),
    .arst_n(arst_n),
    .sec_pulse(sec_pulse),
    .ctrl(ctrl),
    .alarm(active),
    .cal(cal),
    .alarm_event(alarm_event),
    .tick_event(tick_event)
  );

  // Register writes: alarm time staged, controls immediate
  always_comb begin
    next_hold = hold;
    next_active = active;
    next_ctrl = ctrl;
    if (reg_req.wr) begin
      case (reg_req.addr)
        // Time fields land in the holding copy only
        ADDR_ALARM_SEC: begin
          next_hold.sec = reg_req.wdata[5:0];
        end
        ADDR_ALARM_MIN: begin
          next_hold.min = reg_req.wdata[5:0];
        end
        ADDR_ALARM_HOUR: begin
          next_hold.hour = reg_req.wdata[4:0];
        end
        ADDR_ALARM_DOM_FIELD: begin
          next_hold.dom = reg_req.wdata[4:0];
        end
        ADDR_ALARM_MON_FIELD: begin
          next_hold.mon = reg_req.wdata[3:0];
          // Wake permission and period are not staged
          next_ctrl.tick_wake = reg_req.wdata[TICK_WAKE_BIT];
          next_ctrl.tick_type = reg_req.wdata[TICK_TYPE_BIT];
        end
        ADDR_ALARM_YEAR: begin
          // Year write commits the staged fields together
          next_hold.year = reg_req.wdata[5:0];
          next_active = hold;
          next_active.year = reg_req.wdata[5:0];
          next_ctrl.tick_on = reg_req.wdata[TICK_ON_BIT];
          next_ctrl.alarm_on = reg_req.wdata[ALARM_ON_BIT];
        end
        default: begin
          // Read-only or unmapped: write is dropped
        end
      endcase
    end
  end

  // Alarm time and controls; reset gives a valid calendar date
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      hold <= ALARM_TIME_RST;
      active <= ALARM_TIME_RST;
      ctrl <= CTRL_RST;
    end else begin
      hold <= next_hold;
      active <= next_active;
      ctrl <= next_ctrl;
    end
  end

  // Register reads, answered one cycle after the strobe
  always_comb begin
    next_rdata = reg_rdata;
    next_rvalid = reg_req.rd;
    next_snap = snap;
    if (reg_req.rd) begin
      case (reg_req.addr)
        // Alarm reads show the committed alarm time
        ADDR_ALARM_SEC: begin
          next_rdata = {2'b00, active.sec};
        end
        ADDR_ALARM_MIN: begin
          next_rdata = {2'b00, active.min};
        end
        ADDR_ALARM_HOUR: begin
          next_rdata = {3'b000, active.hour};
        end
        ADDR_ALARM_DOM_FIELD: begin
          next_rdata = {3'b000, active.dom};
        end
        ADDR_ALARM_MON_FIELD: begin
          next_rdata = {2'b00, ctrl.tick_wake, ctrl.tick_type, active.mon};
        end
        ADDR_ALARM_YEAR: begin
          next_rdata = {ctrl.tick_on, ctrl.alarm_on, active.year};
        end
        ADDR_SEC_CNT0: begin
          // Latch costs 24 flops but stops a carry tearing the count apart
          // Live low byte, upper bytes frozen for the following reads
          next_rdata = sec_count[7:0];
          next_snap = sec_count[SEC_CNT_W-1:DATA_W];
        end
        ADDR_SEC_CNT1: begin
          next_rdata = snap[7:0];
        end
        ADDR_SEC_CNT2: begin
          next_rdata = snap[15:8];
        end
        ADDR_SEC_CNT3: begin
          next_rdata = snap[23:16];
        end
        default: begin
          // Unmapped reads return zero
          next_rdata = 8'h00;
        end
      endcase
    end
  end

  // Read data and latch; read data holds between reads
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      reg_rdata <= 8'h00;
      reg_rvalid <= 1'b0;
      snap <= '0;
    end else begin
      reg_rdata <= next_rdata;
      reg_rvalid <= next_rvalid;
      snap <= next_snap;
    end
  end

  // Seconds counter and wake request
  always_comb begin
    next_sec_count = sec_pulse ? sec_count + SEC_CNT_W'(1) : sec_count;
    // In rtc-only mode ticks wake only with permission; alarms always wake
    next_wake = rtc_only_mode && (alarm_event || (tick_event && ctrl.tick_wake));
  end

  // Count and wake registered so both stand a full cycle
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      sec_count <= SEC_CNT_RST;
      wake_pulse <= 1'b0;
    end else begin
      sec_count <= next_sec_count;
      wake_pulse <= next_wake;
    end
  end

  // Register side checks; event checks sit in the event generator
  property p_stage_no_commit;
    @(posedge core_clk) disable iff (!arst_n)
    reg_req.wr && !wr_year |=> $stable(active);
  endproperty
  a_stage_no_commit: assert property (p_stage_no_commit)
    else $error("alarm time changed without a year write");

  property p_year_commit;
    @(posedge core_clk) disable iff (!arst_n)
    wr_year |=> active == {$past(reg_req.wdata[5:0]), $past(hold.mon), $past(hold.dom),
                           $past(hold.hour), $past(hold.min), $past(hold.sec)};
  endproperty
  a_year_commit: assert property (p_year_commit)
    else $error("year write did not commit staged fields");

  property p_year_readback;
    @(posedge core_clk) disable iff (!arst_n)
    wr_year ##1 !reg_req.wr ##1
      (reg_req.rd && reg_req.addr == ADDR_ALARM_YEAR && !reg_req.wr)
      |=> reg_rdata == $past(reg_req.wdata, 3);
  endproperty
  a_year_readback: assert property (p_year_readback)
    else $error("year register readback mismatch");

  property p_wake_needs_cause;
    @(posedge core_clk) disable iff (!arst_n)
    wake_pulse |-> $past(rtc_only_mode) && ($past(alarm_event) ||
                   ($past(tick_event) && $past(ctrl.tick_wake)));
  endproperty
  a_wake_needs_cause: assert property (p_wake_needs_cause)
    else $error("wake without permitted cause");

  property p_tick_wakes;
    @(posedge core_clk) disable iff (!arst_n)
    tick_event && ctrl.tick_wake && rtc_only_mode |=> wake_pulse;
  endproperty
  a_tick_wakes: assert property (p_tick_wakes)
    else $error("permitted tick failed to wake");

  property p_low_byte_live;
    @(posedge core_clk) disable iff (!arst_n)
    rd_low |=> reg_rvalid && reg_rdata == $past(sec_count[7:0]) &&
               snap == $past(sec_count[SEC_CNT_W-1:DATA_W]);
  endproperty
  a_low_byte_live: assert property (p_low_byte_live)
    else $error("low byte read or latch wrong");

  property p_snap_only_on_low_read;
    @(posedge core_clk) disable iff (!arst_n)
    !$stable(snap) |-> $past(rd_low);
  endproperty
  a_snap_only_on_low_read: assert property (p_snap_only_on_low_read)
    else $error("upper-byte latch moved without low-byte read");

  property p_top_byte_from_snap;
    @(posedge core_clk) disable iff (!arst_n)
    reg_req.rd && reg_req.addr == ADDR_SEC_CNT3 |=> reg_rdata == $past(snap[23:16]);
  endproperty
  a_top_byte_from_snap: assert property (p_top_byte_from_snap)
    else $error("top byte not from latch");

  property p_byte1_from_snap;
    @(posedge core_clk) disable iff (!arst_n)
    reg_req.rd && reg_req.addr == ADDR_SEC_CNT1 |=> reg_rdata == $past(snap[7:0]);
  endproperty
  a_byte1_from_snap: assert property (p_byte1_from_snap)
    else $error("byte one not from latch");

  property p_byte2_from_snap;
    @(posedge core_clk) disable iff (!arst_n)
    reg_req.rd && reg_req.addr == ADDR_SEC_CNT2 |=> reg_rdata == $past(snap[15:8]);
  endproperty
  a_byte2_from_snap: assert property (p_byte2_from_snap)
    else $error("byte two not from latch");

  property p_read_answer;
    @(posedge core_clk) disable iff (!arst_n)
    reg_req.rd |=> reg_rvalid;
  endproperty
  a_read_answer: assert property (p_read_answer)
    else $error("read strobe got no answer");

  property p_rvalid_cause;
    @(posedge core_clk) disable iff (!arst_n)
    reg_rvalid |-> $past(reg_req.rd);
  endproperty
  a_rvalid_cause: assert property (p_rvalid_cause)
    else $error("read answer without a read");

  property p_sec_count_step;
    @(posedge core_clk) disable iff (!arst_n)
    sec_pulse |=> sec_count == $past(sec_count) + SEC_CNT_W'(1);
  endproperty
  a_sec_count_step: assert property (p_sec_count_step)
    else $error("seconds count missed a second");

  property p_wake_bit_live;
    @(posedge core_clk) disable iff (!arst_n)
    reg_req.wr && reg_req.addr == ADDR_ALARM_MON_FIELD |=>
      ctrl.tick_wake == $past(reg_req.wdata[TICK_WAKE_BIT]);
  endproperty
  a_wake_bit_live: assert property (p_wake_bit_live)
    else $error("tick wake bit not applied at once");

  property p_enables_on_year;
    @(posedge core_clk) disable iff (!arst_n)
    wr_year |=> ctrl.tick_on == $past(reg_req.wdata[TICK_ON_BIT]) &&
                ctrl.alarm_on == $past(reg_req.wdata[ALARM_ON_BIT]);
  endproperty
  a_enables_on_year: assert property (p_enables_on_year)
    else $error("enables not taken from year write");
endmodule

// File: core/rtc_event_gen.sv
`timescale 1ns/1ps
module rtc_event_gen (
  input wire logic core_clk,
  input wire logic arst_n,
  input wire logic sec_pulse,
  input wire rtc_pkg::ctrl_t ctrl,
  input wire rtc_pkg::cal_time_t alarm,
  input wire rtc_pkg::cal_time_t cal,
  output logic alarm_event,
  output logic tick_event
);
  import rtc_pkg::*;

  logic [MIN_CNT_W-1:0] sec_in_min; // Seconds into the current tick minute
  logic [MIN_CNT_W-1:0] next_sec_in_min;
  logic next_alarm_event;
  logic next_tick_event;
  logic min_wrap;

  // Minute boundary and event decisions, all sampled on the second pulse
  always_comb begin
    min_wrap = (sec_in_min == MIN_CNT_W'(SECS_PER_MIN - 1));
    next_sec_in_min = sec_in_min;
    if (sec_pulse) begin
      next_sec_in_min = min_wrap ? '0 : sec_in_min + MIN_CNT_W'(1);
    end
    // Ticks only while enabled; period chosen by tick type
    next_tick_event = sec_pulse && ctrl.tick_on && (!ctrl.tick_type || min_wrap);
    // Alarm compare only runs while enabled
    next_alarm_event = sec_pulse && ctrl.alarm_on && (cal == alarm);
  end

  // Pulses registered so each stands exactly one cycle
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      sec_in_min <= '0;
      alarm_event <= 1'b0;
      tick_event <= 1'b0;
    end else begin
      sec_in_min <= next_sec_in_min;
      alarm_event <= next_alarm_event;
      tick_event <= next_tick_event;
    end
  end

  property p_tick_needs_enable;
    @(posedge core_clk) disable iff (!arst_n)
    tick_event |-> $past(ctrl.tick_on) && $past(sec_pulse);
  endproperty
  a_tick_needs_enable: assert property (p_tick_needs_enable)
    else $error("tick raised without tick enable");

  property p_alarm_match;
    @(posedge core_clk) disable iff (!arst_n)
    sec_pulse && ctrl.alarm_on && (cal == alarm) |=> alarm_event;
  endproperty
  a_alarm_match: assert property (p_alarm_match)
    else $error("alarm missed on match");

  property p_alarm_needs_enable;
    @(posedge core_clk) disable iff (!arst_n)
    alarm_event |-> $past(ctrl.alarm_on) && ($past(cal) == $past(alarm));
  endproperty
  a_alarm_needs_enable: assert property (p_alarm_needs_enable)
    else $error("alarm raised while disabled or mismatched");

  property p_tick_every_second;
    @(posedge core_clk) disable iff (!arst_n)
    sec_pulse && ctrl.tick_on && !ctrl.tick_type |=> tick_event;
  endproperty
  a_tick_every_second: assert property (p_tick_every_second)
    else $error("per-second tick missing");

  property p_tick_minute_only;
    @(posedge core_clk) disable iff (!arst_n)
    tick_event && $past(ctrl.tick_type) |-> $past(sec_in_min) == MIN_CNT_W'(SECS_PER_MIN - 1);
  endproperty
  a_tick_minute_only: assert property (p_tick_minute_only)
    else $error("minute tick off its boundary");
endmodule

// File: core/rtc_pkg.sv
package rtc_pkg;

  // Core clock rate and the derived one-second count
  localparam int unsigned CLK_HZ = 10_000_000;
  localparam int unsigned TICK_PERIOD_S = 1;
  localparam int unsigned CYCLES_PER_SEC = TICK_PERIOD_S * CLK_HZ;
  localparam int unsigned DIV_W = 24;
  localparam int unsigned SECS_PER_MIN = 60;
  localparam int unsigned MIN_CNT_W = 6;

  // Alarm year counts from this base, field covers base to base + 63
  localparam int unsigned YEAR_BASE = 2000;
  localparam int unsigned YEAR_LAST = 2063;

  // Register port widths
  localparam int unsigned ADDR_W = 9;
  localparam int unsigned DATA_W = 8;
  localparam int unsigned SEC_CNT_W = 32;

  // Register offsets
  localparam logic [ADDR_W-1:0] ADDR_ALARM_SEC = 9'h046;
  localparam logic [ADDR_W-1:0] ADDR_ALARM_MIN = 9'h047;
  localparam logic [ADDR_W-1:0] ADDR_ALARM_HOUR = 9'h048;
  localparam logic [ADDR_W-1:0] ADDR_ALARM_DOM_FIELD = 9'h049;
  localparam logic [ADDR_W-1:0] ADDR_ALARM_MON_FIELD = 9'h04A;
  localparam logic [ADDR_W-1:0] ADDR_ALARM_YEAR = 9'h04B;
  localparam logic [ADDR_W-1:0] ADDR_SEC_CNT0 = 9'h04C;
  localparam logic [ADDR_W-1:0] ADDR_SEC_CNT1 = 9'h04D;
  localparam logic [ADDR_W-1:0] ADDR_SEC_CNT2 = 9'h04E;
  localparam logic [ADDR_W-1:0] ADDR_SEC_CNT3 = 9'h04F;

  // Control bit positions inside the month and year registers
  localparam int unsigned TICK_WAKE_BIT = 5;
  localparam int unsigned TICK_TYPE_BIT = 4;
  localparam int unsigned TICK_ON_BIT = 7;
  localparam int unsigned ALARM_ON_BIT = 6;

  // Calendar or alarm time, one field per unit
  typedef struct packed {
    logic [5:0] year;
    logic [3:0] mon;
    logic [4:0] dom;
    logic [4:0] hour;
    logic [5:0] min;
    logic [5:0] sec;
  } cal_time_t;

  // Tick and alarm controls
  typedef struct packed {
    logic tick_on;
    logic alarm_on;
    logic tick_wake;
    logic tick_type;
  } ctrl_t;

  // One register access per cycle
  typedef struct packed {
    logic wr;
    logic rd;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } reg_req_t;

  // Reset values
  localparam cal_time_t ALARM_TIME_RST = '{year: 6'h00, mon: 4'h1, dom: 5'h01,
                                           hour: 5'h00, min: 6'h00, sec: 6'h00};
  localparam ctrl_t CTRL_RST = '{tick_on: 1'b0, alarm_on: 1'b0,
                                 tick_wake: 1'b0, tick_type: 1'b0};
  localparam logic [SEC_CNT_W-1:0] SEC_CNT_RST = 32'h0000_0000;

endpackage

// File: core/rtc_sec_divider.sv
`timescale 1ns/1ps
module rtc_sec_divider #(
  parameter int unsigned CYCLES = rtc_pkg::CYCLES_PER_SEC
) (
  input wire logic core_clk,
  input wire logic arst_n,
  output logic sec_pulse
);
  import rtc_pkg::*;

  logic [DIV_W-1:0] cnt; // Cycles into the current second
  logic [DIV_W-1:0] next_cnt;
  logic next_sec_pulse;

  // Wrap at the end of each second and flag it for one cycle
  always_comb begin
    next_sec_pulse = 1'b0;
    if (cnt == DIV_W'(CYCLES - 1)) begin
      next_cnt = '0;
      next_sec_pulse = 1'b1;
    end else begin
      next_cnt = cnt + DIV_W'(1);
    end
  end

  // Registered so the pulse is glitch free
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      cnt <= '0;
      sec_pulse <= 1'b0;
    end else begin
      cnt <= next_cnt;
      sec_pulse <= next_sec_pulse;
    end
  end
endmodule

// File: test/rtc_alarm_tick_seconds_tb.sv
`timescale 1ns/1ps
module rtc_alarm_tick_seconds_tb;
  import rtc_pkg::*;

  // Short second keeps the run brief
  localparam int unsigned CPS = 20;

  logic core_clk; // Core clock
  logic arst_n; // Async reset, active low
  reg_req_t reg_req; // Register strobe port
  cal_time_t cal; // Live calendar driven by the bench
  logic rtc_only_mode; // Low-power mode level
  logic [DATA_W-1:0] reg_rdata;
  logic reg_rvalid;
  logic alarm_event;
  logic tick_event;
  logic wake_pulse;
  int errors; // Mismatch count
  int checked; // Comparison count
  int nt, na, nw; // Event counts in a window
  logic [SEC_CNT_W-1:0] v1, v2; // Assembled seconds counts
  cal_time_t when; // Programmed alarm time

  rtc_alarm_tick_seconds #(.CYCLES_PER_SEC_P(CPS)) rtc_alarm_tick_seconds_i (
    .core_clk(core_clk),
    .arst_n(arst_n),
    .reg_req(reg_req),
    .cal(cal),
    .rtc_only_mode(rtc_only_mode),
    .reg_rdata(reg_rdata),
    .reg_rvalid(reg_rvalid),
    .alarm_event(alarm_event),
    .tick_event(tick_event),
    .wake_pulse(wake_pulse)
  );

  // 100 ns clock
  initial begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end

  // Verdict and end of run
  task automatic summarize;
    $display("checks %0d errors %0d", checked, errors);
    if (errors == 0 && checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // Case equality so unknowns never match
  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    checked++;
    if (seen !== exp) begin
      errors++;
      $display("wrong value at %0t: %s seen %0h expected %0h", $time, what, seen, exp);
    end
  endtask

  // One write strobe, released after the taking edge
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(posedge core_clk);
    reg_req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge core_clk);
    reg_req <= '0;
  endtask

  // One read; answer lands on the taking edge and is sampled 1 ns later
  task automatic rd(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d);
    @(posedge core_clk);
    reg_req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(posedge core_clk);
    reg_req <= '0;
    #1;
    check({31'h0, reg_rvalid}, 32'h1, "read valid");
    d = reg_rdata;
  endtask

  // Read and compare one register
  task automatic rd_chk(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] exp);
    logic [DATA_W-1:0] d;
    rd(a, d);
    check({24'h0, d}, {24'h0, exp}, "register read");
  endtask

  // Low byte first, upper bytes after a gap of dly cycles
  task automatic read_count(output logic [SEC_CNT_W-1:0] v, input int dly);
    logic [7:0] b0, b1, b2, b3;
    rd(ADDR_SEC_CNT0, b0);
    repeat (dly) @(posedge core_clk);
    rd(ADDR_SEC_CNT1, b1);
    rd(ADDR_SEC_CNT2, b2);
    rd(ADDR_SEC_CNT3, b3);
    v = {b3, b2, b1, b0};
  endtask

  // Count event pulses over n cycles, sampled once settled
  task automatic count_ev(input int n);
    nt = 0;
    na = 0;
    nw = 0;
    repeat (2) @(posedge core_clk);
    repeat (n) begin
      @(posedge core_clk);
      #1;
      if (tick_event === 1'b1) nt++;
      if (alarm_event === 1'b1) na++;
      if (wake_pulse === 1'b1) nw++;
    end
    @(posedge core_clk); // Hand back on an edge so the next drive lands on it
  endtask

  // Hang guard, well beyond the expected ten thousand cycles
  initial begin
    repeat (40000) @(posedge core_clk);
    errors++;
    $display("wrong value at %0t: watchdog expired", $time);
    summarize;
  end

  // Main sequence
  initial begin
    arst_n = 1'b0;
    reg_req = '0;
    cal = ALARM_TIME_RST;
    rtc_only_mode = 1'b0;
    errors = 0;
    checked = 0;
    when = '{year: 6'h05, mon: 4'h7, dom: 5'h05, hour: 5'h03, min: 6'h04, sec: 6'h09};
    repeat (6) @(posedge core_clk);
    arst_n <= 1'b1;
    // Reset contents, unmapped place, untouched latch
    rd_chk(ADDR_ALARM_YEAR, 8'h00);
    rd_chk(9'h050, 8'h00);
    rd_chk(ADDR_SEC_CNT3, 8'h00);
    // Staged fields stay hidden until the year write
    wr(ADDR_ALARM_DOM_FIELD, 8'h05);
    wr(ADDR_ALARM_MON_FIELD, 8'h07);
    wr(ADDR_ALARM_SEC, 8'h09);
    wr(ADDR_ALARM_MIN, 8'h04);
    wr(ADDR_ALARM_HOUR, 8'h03);
    rd_chk(ADDR_ALARM_DOM_FIELD, 8'h01);
    rd_chk(ADDR_ALARM_MON_FIELD, 8'h01);
    wr(ADDR_ALARM_YEAR, 8'h3F);
    rd_chk(ADDR_ALARM_YEAR, 8'h3F);
    rd_chk(ADDR_ALARM_DOM_FIELD, 8'h05);
    rd_chk(ADDR_ALARM_MON_FIELD, 8'h07);
    rd_chk(ADDR_ALARM_HOUR, 8'h03);
    wr(ADDR_ALARM_YEAR, 8'h05);
    // Matching calendar, all enables off; driven on the write's last edge
    cal <= when;
    rtc_only_mode <= 1'b1;
    rd_chk(ADDR_ALARM_YEAR, 8'h05);
    count_ev(10 * CPS);
    check(nt, 0, "tick while off");
    check(na, 0, "alarm while off");
    // Ticks each second, wake bit clear
    wr(ADDR_ALARM_YEAR, 8'h85);
    count_ev(10 * CPS);
    check(nt, 10, "ticks per second");
    check(nw, 0, "wake without bit");
    // Wake bit set, month value unchanged
    wr(ADDR_ALARM_MON_FIELD, 8'h27);
    count_ev(10 * CPS);
    check(nw, 10, "wake on tick");
    // Outside low-power mode nothing wakes
    rtc_only_mode <= 1'b0;
    count_ev(10 * CPS);
    check(nw, 0, "wake out of mode");
    // Minute period
    wr(ADDR_ALARM_MON_FIELD, 8'h17);
    count_ev(120 * CPS);
    check(nt, 2, "ticks per minute");
    // Alarm only, calendar matching
    wr(ADDR_ALARM_MON_FIELD, 8'h07);
    wr(ADDR_ALARM_YEAR, 8'h45);
    count_ev(10 * CPS);
    check(na, 10, "alarm on match");
    check(nt, 0, "tick after disable");
    // One second apart: no alarm
    cal <= '{year: 6'h05, mon: 4'h7, dom: 5'h05, hour: 5'h03, min: 6'h04, sec: 6'h0A};
    count_ev(10 * CPS);
    check(na, 0, "alarm on mismatch");
    // Low byte reads 6000 cycles apart; upper bytes read 260 s late
    read_count(v1, 260 * CPS);
    wr(ADDR_SEC_CNT0, 8'hFF);
    repeat (790) @(posedge core_clk);
    read_count(v2, 0);
    check(v2 - v1, 32'h0000012C, "seconds elapsed");
    summarize;
  end
endmodule
